// >>> pefs_port_e_bus_control_select.sv
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "pefs_map.svh"

module pefs_port_e_bus_control_select (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic ext_access,
    // Decoded mode classes
    input wire logic mode_normal,
    input wire logic mode_emul,
    input wire logic mode_special,
    input wire logic mode_single_chip,
    input wire logic mode_expanded,
    input wire logic mode_narrow,
    input wire logic mode_peripheral,
    input wire logic port_e_emulation_bit,
    // Internal bus control sources
    input wire logic free_cycle_flag,
    input wire logic queue_status_hi,
    input wire logic queue_status_lo,
    input wire logic bus_e_clock,
    input wire logic low_byte_strobe,
    input wire logic bus_rw,
    input wire logic tag_enable,
    // General-purpose I/O sources
    input wire logic [7:2] port_e_data_reg,
    input wire logic [7:2] port_e_direction,
    input wire logic low_tag_input,
    // Port E pins 7:2, tag sample and status outputs
    output logic [7:2] pe_out,
    output logic [7:2] pe_oe,
    output logic low_tag_sampled,
    output logic port_e_regs_unmapped,
    output logic [7:0] port_e_function_select
);

    // ----------------------------------------------------------------
    // Mode decoding
    // ----------------------------------------------------------------
    pefs_pkg::pefs_class_t cls;
    logic in_map;
    logic [7:0] rst_val;
    logic bus_gate;
    logic lstr_gate;

    always_comb begin
        if (mode_emul) begin
            cls = pefs_pkg::PEFS_CLS_EMUL;
        end else if (mode_special) begin
            cls = pefs_pkg::PEFS_CLS_SPECIAL;
        end else begin
            cls = pefs_pkg::PEFS_CLS_NORMAL;
        end
    end

    assign in_map = !(mode_expanded || mode_peripheral);
    assign bus_gate = !(mode_single_chip || mode_peripheral);
    assign lstr_gate = bus_gate && !(mode_normal && mode_expanded && mode_narrow);

    // Reset value chosen from the mode class and the single-chip/expanded/peripheral inputs on the first enabled edge after reset is released
    always_comb begin
        if (mode_emul) begin
            rst_val = `PEFS_RST_EMUL;
        end else if (mode_special && !mode_single_chip && !mode_peripheral) begin
            rst_val = `PEFS_RST_SPEC;
        end else if (mode_normal && mode_single_chip) begin
            rst_val = `PEFS_RST_NSC;
        end else if (mode_normal && mode_expanded) begin
            rst_val = `PEFS_RST_NEXP;
        end else begin
            rst_val = `PEFS_RST_ZERO;
        end
    end

    // ----------------------------------------------------------------
    // APB access
    // ----------------------------------------------------------------
    logic hit;
    logic wr_en;
    logic rd_en;
    logic load_q;
    logic once_used_q;
    logic [7:0] sel_q;
    logic [7:0] wmask;

    assign hit = (paddr == `PEFS_SEL_ADDR) && in_map;
    // Write lands at the access edge, where the master samples pready high
    assign wr_en = clk_en && psel && penable && pready && pwrite && hit;
    assign rd_en = clk_en && psel && !penable && !pwrite;

    // Per-bit write permission by mode class
    function automatic logic [7:0] pefs_wmask(input pefs_pkg::pefs_class_t c, input logic used);
        logic [7:0] m;
        m = 8'h00;
        case (c)
            pefs_pkg::PEFS_CLS_SPECIAL: m = `PEFS_IMPL_MASK;
            pefs_pkg::PEFS_CLS_NORMAL: begin
                m = 8'h00;
                m[`PEFS_EDIS_BIT] = 1'b1;
                if (!used) begin
                    m = m | `PEFS_ONCE_MASK;
                end
            end
            pefs_pkg::PEFS_CLS_EMUL: m = 8'h00;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    assign wmask = pefs_wmask(cls, once_used_q);

    // Reset is asynchronous to a constant; the mode-dependent value loads on the first edge after
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_q <= 1'b1;
        end else if (clk_en) begin
            load_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= `PEFS_RST_ZERO;
        end else if (clk_en && load_q) begin
            sel_q <= rst_val;
        end else if (wr_en) begin
            sel_q <= (sel_q & ~wmask) | (pwdata[7:0] & wmask & `PEFS_IMPL_MASK);
        end
    end

    // The one allowed normal-mode write is spent by any write to the mapped register in normal mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            once_used_q <= 1'b0;
        end else if (clk_en && load_q) begin
            once_used_q <= 1'b0;
        end else if (wr_en && cls == pefs_pkg::PEFS_CLS_NORMAL) begin
            once_used_q <= 1'b1;
        end
    end

    // Zero-wait slave: answers in the access cycle with registered data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            ext_access <= 1'b0;
        end else if (clk_en) begin
            if (rd_en) begin
                prdata <= hit ? {24'h00_0000, sel_q & `PEFS_IMPL_MASK} : 32'h0000_0000;
            end
            if (psel && !penable) begin
                ext_access <= (paddr == `PEFS_SEL_ADDR) && !in_map;
            end else if (!psel) begin
                ext_access <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Pin multiplexing
    // ----------------------------------------------------------------
    logic free_on;
    logic queue_on;
    logic eclock_on;
    logic lstr_on;
    logic rw_on;
    logic e_prev_q;
    logic strobe_q;
    logic [7:2] out_d;
    logic [7:2] oe_d;

    assign free_on = !sel_q[`PEFS_FREE_BIT] && bus_gate;
    assign queue_on = sel_q[`PEFS_QUEUE_BIT] && bus_gate;
    assign eclock_on = !sel_q[`PEFS_EDIS_BIT];
    assign lstr_on = sel_q[`PEFS_LSTR_BIT] && lstr_gate;
    assign rw_on = sel_q[`PEFS_RW_BIT] && bus_gate;

    // Tag sampled on E rise, strobe launched on E fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            e_prev_q <= 1'b0;
            strobe_q <= 1'b0;
            low_tag_sampled <= 1'b0;
        end else if (clk_en) begin
            e_prev_q <= bus_e_clock;
            if (bus_e_clock && !e_prev_q && tag_enable && lstr_on) begin
                low_tag_sampled <= low_tag_input;
            end
            if (!bus_e_clock && e_prev_q) begin
                strobe_q <= low_byte_strobe;
            end
        end
    end

    always_comb begin
        out_d = port_e_data_reg;
        oe_d = port_e_direction;
        if (free_on) begin
            out_d[7] = free_cycle_flag;
            oe_d[7] = 1'b1;
        end
        if (queue_on) begin
            out_d[6] = queue_status_hi;
            out_d[5] = queue_status_lo;
            oe_d[6] = 1'b1;
            oe_d[5] = 1'b1;
        end
        if (eclock_on) begin
            out_d[4] = bus_e_clock;
            oe_d[4] = 1'b1;
        end
        if (lstr_on) begin
            out_d[3] = tag_enable ? strobe_q : low_byte_strobe;
            oe_d[3] = 1'b1;
        end
        if (rw_on) begin
            out_d[2] = bus_rw;
            oe_d[2] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pe_out <= 6'h00;
            pe_oe <= 6'h00;
            port_e_regs_unmapped <= 1'b0;
            port_e_function_select <= 8'h00;
        end else if (clk_en) begin
            pe_out <= out_d;
            pe_oe <= oe_d;
            port_e_regs_unmapped <= port_e_emulation_bit && (mode_expanded || mode_peripheral);
            port_e_function_select <= sel_q;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_emul_write;
        wr_en && cls == pefs_pkg::PEFS_CLS_EMUL && !load_q;
    endsequence

    a_emul_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        s_emul_write |=> $stable(sel_q)) else $error("emulation write changed select");
    a_eclock_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !sel_q[`PEFS_EDIS_BIT] |=> pe_oe[4] && pe_out[4] == $past(bus_e_clock))
        else $error("E clock not on pin 4");
    a_unimpl_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (prdata[6] == 1'b0) && (prdata[1:0] == 2'b00) && (prdata[31:8] == 24'h00_0000))
        else $error("unimplemented bits read nonzero");
    a_unmapped_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && penable && pwrite && !in_map && !load_q |=> $stable(sel_q))
        else $error("write landed while unmapped");
    a_free_gated_off: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && mode_single_chip && !port_e_direction[7] |=> !pe_oe[7])
        else $error("free cycle pin driven in single chip");
    a_once_then_locked: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && cls == pefs_pkg::PEFS_CLS_NORMAL && once_used_q && !load_q |=>
        (sel_q & `PEFS_ONCE_MASK) == ($past(sel_q) & `PEFS_ONCE_MASK))
        else $error("second normal write took effect");
    a_nsc_reset_val: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && load_q && mode_normal && mode_single_chip |=> sel_q == `PEFS_RST_NSC)
        else $error("normal single chip reset value wrong");
    a_rw_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && rw_on |=> pe_oe[2] && pe_out[2] == $past(bus_rw))
        else $error("R/W pin not driven");
    a_queue_pins: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && queue_on |=> pe_oe[6:5] == 2'b11) else $error("queue pins not driven");
    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && !penable |=> pready) else $error("no ready after setup");
    a_emul_reset_val: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && load_q && mode_emul |=> sel_q == `PEFS_RST_EMUL)
        else $error("emulation reset value wrong");
    a_spec_reset_val: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && load_q && mode_special && !mode_emul && !mode_single_chip && !mode_peripheral
        |=> sel_q == `PEFS_RST_SPEC) else $error("special test reset value wrong");
    a_nexp_reset_val: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && load_q && mode_normal && mode_expanded && !mode_emul && !mode_special
        |=> sel_q == `PEFS_RST_NEXP) else $error("normal expanded reset value wrong");
    a_free_pin_drive: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && free_on |=> pe_oe[7] && pe_out[7] == $past(free_cycle_flag))
        else $error("free cycle flag not on pin 7");
    a_lstr_gated_off: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !lstr_gate && !port_e_direction[3] |=> !pe_oe[3])
        else $error("strobe pin driven while gated");
    a_ext_echo: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && psel && !penable && paddr == `PEFS_SEL_ADDR && !in_map |=> ext_access)
        else $error("unmapped access not passed out");
    a_regs_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && port_e_emulation_bit && mode_expanded |=> port_e_regs_unmapped)
        else $error("port registers left mapped");

    // Tag capture has two steps: an E rise, then the held sample
    sequence s_tag_rise;
        clk_en && tag_enable && lstr_on && bus_e_clock && !e_prev_q;
    endsequence

    a_tag_on_rise: assert property (@(posedge pclk) disable iff (!presetn)
        s_tag_rise |=> low_tag_sampled == $past(low_tag_input))
        else $error("low tag not sampled on E rise");

endmodule
`default_nettype wire

// >>> pefs_map.svh
`ifndef PEFS_MAP_SVH
`define PEFS_MAP_SVH

// Register byte address on APB (printed offset is not word aligned: index times four)
`define PEFS_SEL_INDEX 8'h0A
`define PEFS_SEL_ADDR 12'h028

// Field positions
`define PEFS_FREE_BIT 7
`define PEFS_QUEUE_BIT 5
`define PEFS_EDIS_BIT 4
`define PEFS_LSTR_BIT 3
`define PEFS_RW_BIT 2

// Implemented bits and write-once subset
`define PEFS_IMPL_MASK 8'hBC
`define PEFS_ONCE_MASK 8'hAC

// Reset values by mode class
`define PEFS_RST_NSC 8'h10
`define PEFS_RST_NEXP 8'h00
`define PEFS_RST_SPEC 8'h2C
`define PEFS_RST_EMUL 8'hAC
`define PEFS_RST_ZERO 8'h00

`endif

// >>> pefs_pkg.sv
package pefs_pkg;
    typedef enum logic [1:0] {
        PEFS_CLS_NORMAL,
        PEFS_CLS_EMUL,
        PEFS_CLS_SPECIAL
    } pefs_class_t;
endpackage

// >>> pefs_bus_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module pefs_bus_src_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Internal bus control sources
    output logic bus_e_clock,
    output logic free_cycle_flag,
    output logic queue_status_hi,
    output logic queue_status_lo,
    output logic low_byte_strobe,
    output logic bus_rw,
    output logic low_tag_input
);
    logic [3:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    assign bus_e_clock = cnt_q[0];
    assign free_cycle_flag = cnt_q[1];
    assign queue_status_hi = cnt_q[2];
    assign queue_status_lo = cnt_q[1] ^ cnt_q[3];
    // No write early after reset, so software has time to enable the strobe
    assign bus_rw = ~(cnt_q[3] & cnt_q[2]);
    // Strobe only on writes: reads drive every data lane anyway
    assign low_byte_strobe = ~bus_rw & cnt_q[0];
    assign low_tag_input = ~cnt_q[1];
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ----------------
    // Signals
    // ----------------
    logic pclk, presetn, psel, penable, pwrite, emu_bit, pready, ext_access, ext, unm;
    logic tag_en, tag_s, slverr, tg;
    logic [4:0] pv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [6:0] md;
    logic [7:2] gp_data, gp_dir, pe_out, pe_oe;
    logic [7:0] sel;
    logic [21:0] tbl [8];
    logic [21:0] c;
    wire logic e_clk, free_f, q_hi, q_lo, lstr, rw, tag_lo;
    int failures, n_compared;

    pefs_bus_src_model u_src (.pclk(pclk), .presetn(presetn), .bus_e_clock(e_clk),
        .free_cycle_flag(free_f), .queue_status_hi(q_hi), .queue_status_lo(q_lo),
        .low_byte_strobe(lstr), .bus_rw(rw), .low_tag_input(tag_lo));

    pefs_port_e_bus_control_select u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(slverr), .ext_access(ext_access),
        .mode_normal(md[6]), .mode_emul(md[5]), .mode_special(md[4]),
        .mode_single_chip(md[3]), .mode_expanded(md[2]), .mode_narrow(md[1]),
        .mode_peripheral(md[0]), .port_e_emulation_bit(emu_bit), .free_cycle_flag(free_f),
        .queue_status_hi(q_hi), .queue_status_lo(q_lo), .bus_e_clock(e_clk),
        .low_byte_strobe(lstr), .bus_rw(rw), .tag_enable(tag_en),
        .port_e_data_reg(gp_data), .port_e_direction(gp_dir), .low_tag_input(tag_lo),
        .pe_out(pe_out), .pe_oe(pe_oe), .low_tag_sampled(tag_s), .port_e_regs_unmapped(unm),
        .port_e_function_select(sel));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ----------------
    // Tasks
    // ----------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        chk("pslverr", 32'h0, {31'h0, slverr});
        rd = prdata;
        ext = ext_access;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rst(input logic [6:0] m);
        @(posedge pclk);
        presetn <= 1'b0;
        md <= m;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------
    // Tests
    // ----------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, tag_en} = '0;
        md = 7'h48;
        emu_bit = 1'b1;
        gp_data = 6'h2A;
        gp_dir = 6'h00;
        failures = 0;
        n_compared = 0;
        // Mode, reset value, pin enables with all pins inputs, mapped
        tbl = '{{7'h48, 8'h10, 6'h00, 1'b1}, {7'h46, 8'h00, 6'h24, 1'b0},
                {7'h44, 8'h00, 6'h24, 1'b0}, {7'h18, 8'h00, 6'h04, 1'b1},
                {7'h14, 8'h2C, 6'h3F, 1'b0}, {7'h26, 8'hAC, 6'h1F, 1'b0},
                {7'h24, 8'hAC, 6'h1F, 1'b0}, {7'h11, 8'h00, 6'h04, 1'b0}};
        for (int i = 0; i < 8; i++) begin
            c = tbl[i];
            rst(c[21:15]);
            chk("reset value", {24'h0, c[14:7]}, {24'h0, sel});
            chk("pin enables", {26'h0, c[6:1]}, {26'h0, pe_oe});
            chk("regs unmapped", {31'h0, ~c[0]}, {31'h0, unm});
            apb(1'b0, 12'h028, 32'h0);
            chk("select read", c[0] ? {24'h0, c[14:7]} : 32'h0, rd);
            chk("external access", {31'h0, ~c[0]}, {31'h0, ext});
        end
        $display("test mode table done");

        rst(7'h48);
        gp_dir <= 6'h3F;
        repeat (3) @(posedge pclk);
        chk("gpio enables", 32'h3F, {26'h0, pe_oe});
        chk("gpio data", 32'h2A, {26'h0, pe_out});
        gp_dir <= 6'h00;
        apb(1'b1, 12'h028, 32'hFFFFFFFF);
        apb(1'b0, 12'h028, 32'h0);
        chk("first normal write", 32'hBC, rd);
        repeat (3) @(posedge pclk);
        chk("single chip pins", 32'h00, {26'h0, pe_oe});
        apb(1'b1, 12'h028, 32'h0);
        apb(1'b0, 12'h028, 32'h0);
        chk("second normal write", 32'hAC, rd);
        repeat (3) @(posedge pclk);
        chk("e clock pin", 32'h04, {26'h0, pe_oe});
        $display("test normal single chip writes done");

        rst(7'h18);
        apb(1'b1, 12'h028, 32'h000000AC);
        apb(1'b0, 12'h028, 32'h0);
        chk("special write one", 32'hAC, rd);
        apb(1'b1, 12'h028, 32'h00000004);
        apb(1'b0, 12'h028, 32'h0);
        chk("special write two", 32'h04, rd);
        apb(1'b0, 12'h02C, 32'h0);
        chk("other address", 32'h0, rd);
        $display("test special writes done");

        // Emulation class with the register mapped: every write must be ignored
        rst(7'h20);
        apb(1'b1, 12'h028, 32'h00000000);
        apb(1'b0, 12'h028, 32'h0);
        chk("emulation write", 32'hAC, rd);
        $display("test emulation writes done");

        // Special test with tagging: pins follow the sources one cycle late
        tag_en <= 1'b1;
        rst(7'h14);
        for (int k = 0; k < 2; k++) begin
            do @(posedge pclk); while (e_clk !== 1'b1);
            tg = tag_lo;
            pv = {free_f, q_hi, q_lo, e_clk, rw};
            @(posedge pclk);
            chk("low tag sample", {31'h0, tg}, {31'h0, tag_s});
            chk("bus pins", {27'h0, pv}, {27'h0, pe_out[7:4], pe_out[2]});
        end
        $display("test bus control pins done");

        emu_bit <= 1'b0;
        rst(7'h44);
        chk("regs mapped", 32'h0, {31'h0, unm});
        $display("test port emulation bit done");
        close_out();
    end

    // Whole run is under two hundred cycles; this leaves a wide margin
    initial begin
        #50000;
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
